/* logic/usff_map.svh */
`ifndef USFF_MAP_SVH
`define USFF_MAP_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define USFF_IDX_STAT 10'h0C0
`define USFF_IDX_CTLB 10'h0C1
`define USFF_IDX_FMT 10'h0C2
`define USFF_IDX_DIVLO 10'h0C4
`define USFF_IDX_DIVHI 10'h0C5
`define USFF_IDX_DATA 10'h0C6

// ----------------------------------------
// Field positions
// ----------------------------------------
`define USFF_FMT_POL 0
`define USFF_FMT_SZLO 1
`define USFF_FMT_STOP 3
`define USFF_FMT_PODD 4
`define USFF_FMT_PEN 5
`define USFF_FMT_SYNC 6
`define USFF_CTLB_TX9 0
`define USFF_CTLB_RX9 1
`define USFF_CTLB_SZHI 2
`define USFF_CTLB_TXEN 3
`define USFF_CTLB_RXEN 4
`define USFF_STAT_DBL 1
`define USFF_STAT_TXE 5
`define USFF_STAT_RXC 7

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define USFF_FMT_RST 8'h06
`define USFF_DIV_W 12
`define USFF_CODE_NINE 3'h7
`define USFF_SUB_NORMAL 4'hF
`define USFF_SUB_DOUBLE 4'h7

`endif

/* logic/usff_pkg.sv */
`include "usff_map.svh"

package usff_pkg;

	typedef enum logic [1:0] {
		USFF_TX_IDLE = 2'b00,
		USFF_TX_DATA = 2'b01,
		USFF_TX_PAR = 2'b10,
		USFF_TX_STOP = 2'b11
	} usff_tx_t;

	typedef enum logic [2:0] {
		USFF_RX_IDLE = 3'b000,
		USFF_RX_START = 3'b001,
		USFF_RX_DATA = 3'b010,
		USFF_RX_PAR = 3'b011,
		USFF_RX_STOP = 3'b100
	} usff_rx_t;

	typedef struct packed {
		logic [`USFF_DIV_W-1:0] cnt;
		logic tick;
	} usff_bg_t;

	typedef struct packed {
		logic [7:0] divLo;
		logic [3:0] divHi;
		logic reload;
		logic [7:0] fmt;
		logic [4:0] ctlB;
		logic dblSpeed;
		logic [31:0] rdata;
		logic [2:0] xckSync;
		logic xckLvl;
		logic [2:0] rxdSync;
		logic rxdLvl;
		logic [3:0] txSub;
		usff_tx_t txState;
		logic [8:0] txBuf;
		logic txFull;
		logic [8:0] txShift;
		logic [3:0] txCnt;
		logic txPar;
		logic txd;
		usff_rx_t rxState;
		logic [3:0] rxSub;
		logic [3:0] rxCnt;
		logic [8:0] rxShift;
		logic [8:0] rxData;
		logic rxFull;
	} usff_state_t;

endpackage

/* logic/usff_baud_gen.sv */
`timescale 1ns/100ps
`default_nettype none
`include "usff_map.svh"

module usff_baud_gen
	import usff_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [`USFF_DIV_W-1:0] divisor,
	input wire logic reload,
	output logic baudTick
);

	usff_bg_t s_reg;
	usff_bg_t s_next;

	// ----------------------------------------
	// Prescaler: one tick every divisor+1 clocks
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.tick = 1'b0;
		if (reload) begin
			s_next.cnt = divisor;
		end else if (s_reg.cnt == '0) begin
			s_next.cnt = divisor;
			s_next.tick = 1'b1;
		end else begin
			s_next.cnt = s_reg.cnt - `USFF_DIV_W'(1);
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s_reg <= '{default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign baudTick = s_reg.tick;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_reload_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
		reload |=> (s_reg.cnt == $past(divisor)) && !baudTick)
		else $error("prescaler not reloaded by low divisor write");
	chk_div_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(!reload && divisor == '0 && s_reg.cnt == '0) [*2] |-> baudTick ##1 baudTick)
		else $error("divisor zero does not tick every clock");

endmodule

`default_nettype wire

/* logic/usff_frame_baud.sv */
`timescale 1ns/100ps
`default_nettype none
`include "usff_map.svh"

module usff_frame_baud
	import usff_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxdPin,
	input wire logic xckPin,
	output logic txdPin
);

	// ----------------------------------------
	// State and decode
	// ----------------------------------------
	localparam usff_state_t STATE_RST = '{fmt: `USFF_FMT_RST, xckSync: 3'h0,
		rxdSync: 3'h7, rxdLvl: 1'b1, txd: 1'b1, txState: USFF_TX_IDLE,
		rxState: USFF_RX_IDLE, default: '0};

	usff_state_t s_reg;
	usff_state_t s_next;
	logic baudTick;
	logic [9:0] idx;
	logic hit, setup, wrAcc, rdAcc;
	logic syncMode, pol, stop2, parEn, txEn, rxEn;
	logic [3:0] lim, nBits;
	logic [2:0] sizeCode;
	logic xckRise, xckFall, txEdge, rxEdge, txAdv, rxSample;
	logic [8:0] rxAligned;

	assign idx = paddr[11:2];
	assign setup = psel && !penable;
	assign wrAcc = psel && penable && pwrite;
	assign rdAcc = psel && penable && !pwrite;
	assign hit = (idx == `USFF_IDX_STAT) || (idx == `USFF_IDX_CTLB) ||
		(idx == `USFF_IDX_FMT) || (idx == `USFF_IDX_DIVLO) ||
		(idx == `USFF_IDX_DIVHI) || (idx == `USFF_IDX_DATA);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign prdata = s_reg.rdata;
	assign txdPin = s_reg.txd;

	assign syncMode = s_reg.fmt[`USFF_FMT_SYNC];
	assign pol = s_reg.fmt[`USFF_FMT_POL];
	assign stop2 = s_reg.fmt[`USFF_FMT_STOP];
	assign parEn = s_reg.fmt[`USFF_FMT_PEN];
	assign txEn = s_reg.ctlB[`USFF_CTLB_TXEN];
	assign rxEn = s_reg.ctlB[`USFF_CTLB_RXEN];
	assign sizeCode = {s_reg.ctlB[`USFF_CTLB_SZHI], s_reg.fmt[`USFF_FMT_SZLO +: 2]};
	// Reserved size codes fall back to eight bits
	assign nBits = (sizeCode == `USFF_CODE_NINE) ? 4'd9 :
		(sizeCode[2] ? 4'd8 : 4'd5 + {2'b00, sizeCode[1:0]});
	assign lim = s_reg.dblSpeed ? `USFF_SUB_DOUBLE : `USFF_SUB_NORMAL;

	// ----------------------------------------
	// Serial clock edges, taken once stages two and three agree
	// ----------------------------------------
	assign xckRise = (s_reg.xckSync[1] == s_reg.xckSync[2]) && s_reg.xckSync[2] && !s_reg.xckLvl;
	assign xckFall = (s_reg.xckSync[1] == s_reg.xckSync[2]) && !s_reg.xckSync[2] && s_reg.xckLvl;
	assign txEdge = pol ? xckFall : xckRise;
	assign rxEdge = pol ? xckRise : xckFall;
	// Async bit time is lim+1 prescaler ticks
	assign txAdv = syncMode ? txEdge : (baudTick && s_reg.txSub == lim);
	assign rxSample = syncMode ? rxEdge : (baudTick && s_reg.rxSub ==
		((s_reg.rxState == USFF_RX_START) ? {1'b0, lim[3:1]} : lim));
	assign rxAligned = s_reg.rxShift >> (4'd9 - nBits);

	usff_baud_gen u_baud (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.divisor({s_reg.divHi, s_reg.divLo}),
		.reload(s_reg.reload),
		.baudTick(baudTick)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.reload = 1'b0;
		s_next.xckSync = {s_reg.xckSync[1:0], xckPin};
		s_next.rxdSync = {s_reg.rxdSync[1:0], rxdPin};
		if (s_reg.xckSync[1] == s_reg.xckSync[2]) begin
			s_next.xckLvl = s_reg.xckSync[2];
		end
		if (s_reg.rxdSync[1] == s_reg.rxdSync[2]) begin
			s_next.rxdLvl = s_reg.rxdSync[2];
		end
		if (baudTick) begin
			s_next.txSub = (s_reg.txSub == lim) ? 4'h0 : s_reg.txSub + 4'h1;
			s_next.rxSub = s_reg.rxSub + 4'h1;
		end

		// Register reads are captured in the setup cycle
		if (setup) begin
			unique case (idx)
				`USFF_IDX_STAT: s_next.rdata = {24'h000000, s_reg.rxFull, 1'b0, !s_reg.txFull,
					3'h0, s_reg.dblSpeed, 1'b0};
				`USFF_IDX_CTLB: s_next.rdata = {24'h000000, 3'h0, s_reg.ctlB[4:2],
					s_reg.rxData[8], s_reg.ctlB[0]};
				`USFF_IDX_FMT: s_next.rdata = {24'h000000, 1'b0, s_reg.fmt[6:0]};
				`USFF_IDX_DIVLO: s_next.rdata = {24'h000000, s_reg.divLo};
				`USFF_IDX_DIVHI: s_next.rdata = {24'h000000, 4'h0, s_reg.divHi};
				`USFF_IDX_DATA: s_next.rdata = {24'h000000, s_reg.rxData[7:0]};
				default: s_next.rdata = 32'h00000000;
			endcase
		end
		if (wrAcc) begin
			unique case (idx)
				`USFF_IDX_STAT: s_next.dblSpeed = pwdata[`USFF_STAT_DBL];
				`USFF_IDX_CTLB: begin
					s_next.ctlB = {pwdata[4:2], 1'b0, pwdata[0]};
				end
				`USFF_IDX_FMT: s_next.fmt = {1'b0, pwdata[6:0]};
				`USFF_IDX_DIVLO: begin
					s_next.divLo = pwdata[7:0];
					s_next.reload = 1'b1;
				end
				`USFF_IDX_DIVHI: s_next.divHi = pwdata[3:0];
				`USFF_IDX_DATA: begin
					// Writes while the buffer is full are dropped
					if (!s_reg.txFull) begin
						s_next.txBuf = {s_reg.ctlB[`USFF_CTLB_TX9], pwdata[7:0]};
						s_next.txFull = 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (rdAcc && idx == `USFF_IDX_DATA) begin
			s_next.rxFull = 1'b0;
		end

		// ----------------------------------------
		// Transmitter
		// ----------------------------------------
		unique case (s_reg.txState)
			USFF_TX_IDLE: begin
				if (txAdv && txEn && s_reg.txFull) begin
					s_next.txd = 1'b0;
					s_next.txShift = s_reg.txBuf;
					s_next.txFull = 1'b0;
					s_next.txCnt = 4'h0;
					s_next.txPar = s_reg.fmt[`USFF_FMT_PODD];
					s_next.txState = USFF_TX_DATA;
				end
			end
			USFF_TX_DATA: begin
				if (txAdv) begin
					s_next.txd = s_reg.txShift[0];
					s_next.txShift = {1'b0, s_reg.txShift[8:1]};
					s_next.txPar = s_reg.txPar ^ s_reg.txShift[0];
					s_next.txCnt = s_reg.txCnt + 4'h1;
					if (s_reg.txCnt == nBits - 4'h1) begin
						s_next.txCnt = 4'h0;
						s_next.txState = parEn ? USFF_TX_PAR : USFF_TX_STOP;
					end
				end
			end
			USFF_TX_PAR: begin
				if (txAdv) begin
					s_next.txd = s_reg.txPar;
					s_next.txState = USFF_TX_STOP;
				end
			end
			USFF_TX_STOP: begin
				if (txAdv) begin
					s_next.txd = 1'b1;
					s_next.txCnt = s_reg.txCnt + 4'h1;
					if (s_reg.txCnt == {3'h0, stop2}) begin
						s_next.txCnt = 4'h0;
						s_next.txState = USFF_TX_IDLE;
					end
				end
			end
		endcase

		// ----------------------------------------
		// Receiver: one stop bit, level unchecked, whatever the stop select
		// ----------------------------------------
		unique case (s_reg.rxState)
			USFF_RX_IDLE: begin
				if (rxEn && !s_reg.rxdLvl && (!syncMode || rxEdge)) begin
					s_next.rxSub = 4'h0;
					s_next.rxCnt = 4'h0;
					s_next.rxState = syncMode ? USFF_RX_DATA : USFF_RX_START;
				end
			end
			USFF_RX_START: begin
				if (rxSample) begin
					s_next.rxSub = 4'h0;
					s_next.rxState = s_reg.rxdLvl ? USFF_RX_IDLE : USFF_RX_DATA;
				end
			end
			USFF_RX_DATA: begin
				if (rxSample) begin
					s_next.rxSub = 4'h0;
					s_next.rxShift = {s_reg.rxdLvl, s_reg.rxShift[8:1]};
					s_next.rxCnt = s_reg.rxCnt + 4'h1;
					if (s_reg.rxCnt == nBits - 4'h1) begin
						s_next.rxState = parEn ? USFF_RX_PAR : USFF_RX_STOP;
					end
				end
			end
			USFF_RX_PAR: begin
				if (rxSample) begin
					s_next.rxSub = 4'h0;
					s_next.rxState = USFF_RX_STOP;
				end
			end
			USFF_RX_STOP: begin
				if (rxSample) begin
					// New character wins over a same-cycle buffer read
					s_next.rxData = rxAligned;
					s_next.rxFull = 1'b1;
					s_next.rxState = USFF_RX_IDLE;
				end
			end
			default: s_next.rxState = USFF_RX_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s_reg <= STATE_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	chk_one_stop: assert property (
		s_reg.txState == USFF_TX_STOP && txAdv && s_reg.txCnt == 4'h0 && !stop2
		|=> s_reg.txState == USFF_TX_IDLE && txdPin)
		else $error("one stop bit frame did not end");
	chk_two_stop: assert property (
		s_reg.txState == USFF_TX_STOP && txAdv && s_reg.txCnt == 4'h0 && stop2
		|=> s_reg.txState == USFF_TX_STOP && s_reg.txCnt == 4'h1)
		else $error("second stop bit missing");
	chk_rx_stop: assert property (
		s_reg.rxState == USFF_RX_STOP && rxSample |=> s_reg.rxState == USFF_RX_IDLE && s_reg.rxFull)
		else $error("receiver did not finish after first stop bit");
	chk_size_nine: assert property (
		sizeCode == `USFF_CODE_NINE |-> nBits == 4'd9)
		else $error("size code 111 is not nine bits");
	chk_sync_shift: assert property (
		syncMode && s_reg.txState == USFF_TX_DATA && txEdge |=> txdPin == $past(s_reg.txShift[0]))
		else $error("sync data did not shift on launch edge");
	chk_sync_hold: assert property (
		syncMode && !txEdge |=> $stable(txdPin))
		else $error("sync output moved without clock edge");
	chk_divhi_read: assert property (
		setup && idx == `USFF_IDX_DIVHI |=> prdata[7:4] == 4'h0 && prdata[3:0] == s_reg.divHi)
		else $error("high divisor reserved bits not zero");
	chk_divlo_reload: assert property (
		wrAcc && idx == `USFF_IDX_DIVLO |=> s_reg.reload && s_reg.divLo == $past(pwdata[7:0]))
		else $error("low divisor write did not request reload");
	chk_double_rate: assert property (
		!syncMode && s_reg.dblSpeed && baudTick && s_reg.txSub == 4'h7 |-> txAdv)
		else $error("double speed bit time not eight ticks");
	chk_start_low: assert property (
		s_reg.txState == USFF_TX_IDLE ##1 s_reg.txState == USFF_TX_DATA |-> !txdPin)
		else $error("frame did not open with low start bit");

	cov_two_stop: cover property (s_reg.txState == USFF_TX_STOP && stop2 && s_reg.txCnt == 4'h1);
	cov_rx_nine: cover property (s_reg.rxState == USFF_RX_STOP && rxSample && nBits == 4'd9);
	cov_sync_tx: cover property (syncMode && s_reg.txState == USFF_TX_DATA && txEdge);
	cov_divlo: cover property (wrAcc && idx == `USFF_IDX_DIVLO);

endmodule

`default_nettype wire

/* verif/usff_remote_peer.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Remote serial transceiver
// ----------------------------------------
module usff_remote_peer (
	input wire logic clk_sys,
	input wire logic txdPin,
	output logic rxdPin,
	output logic xckPin
);
	// Serial clock stands still low outside synchronous frames
	initial begin
		rxdPin = 1'h1;
		xckPin = 1'h0;
	end
	// Samples mid-bit: times start edges in ns so that no clock race skews the count
	task automatic catchFrame(input int bitLen, input int nBits, output logic [8:0] d,
		output longint t0, output logic frameOk);
		d = '0;
		@(negedge txdPin);
		t0 = $time;
		repeat (bitLen / 2) @(posedge clk_sys);
		frameOk = ~txdPin;
		for (int i = 0; i < nBits; i++) begin
			repeat (bitLen) @(posedge clk_sys);
			d[i] = txdPin;
		end
		repeat (bitLen) @(posedge clk_sys);
		frameOk = frameOk & txdPin;
	endtask
	// Polarity 0 partner: drives on rising clock, samples the block's data on falling
	task automatic syncXfer(input int half, input logic [9:0] txBits, output logic [9:0] seen);
		seen = '0;
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_sys);
			xckPin <= 1'h1;
			rxdPin <= txBits[i];
			repeat (half) @(posedge clk_sys);
			xckPin <= 1'h0;
			seen[i] = txdPin;
			repeat (half) @(posedge clk_sys);
		end
	endtask
	task automatic sendFrame(input int bitLen, input int nBits, input logic [8:0] d);
		@(posedge clk_sys);
		rxdPin <= 1'h0;
		repeat (bitLen) @(posedge clk_sys);
		for (int i = 0; i < nBits; i++) begin
			rxdPin <= d[i];
			repeat (bitLen) @(posedge clk_sys);
		end
		// Line returns to its idle high level for one stop bit
		rxdPin <= 1'h1;
		repeat (bitLen) @(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

/* verif/usff_frame_baud_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "usff_map.svh"
// ----------------------------------------
// Bench
// ----------------------------------------
module usff_frame_baud_tb_top;
	logic clk_sys = 1'h0;
	logic sys_rst = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready, pslverr, txdPin, rxdPin, xckPin;
	int n_fail = 0;
	int tests_run = 0;
	always #25 clk_sys = ~clk_sys;
	usff_frame_baud u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxdPin(rxdPin), .xckPin(xckPin),
		.txdPin(txdPin));
	usff_remote_peer u_peer (.clk_sys(clk_sys), .txdPin(txdPin), .rxdPin(rxdPin),
		.xckPin(xckPin));
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk_sys);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {idx, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge clk_sys);
		penable <= 1'h1;
		do @(posedge clk_sys); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'h1, idx, d, r, e);
	endtask
	task automatic rd(input logic [9:0] idx, output logic [31:0] r);
		logic e;
		apb(1'h0, idx, 8'h00, r, e);
	endtask
	task automatic testRegs();
		logic [31:0] r;
		logic e;
		rd(`USFF_IDX_FMT, r);
		chk("format reset", r, 32'h06);
		rd(`USFF_IDX_DIVLO, r);
		chk("divisor low reset", r, 32'h00);
		wr(`USFF_IDX_DIVHI, 8'h0F);
		rd(`USFF_IDX_DIVHI, r);
		chk("divisor high", r, 32'h0F);
		wr(`USFF_IDX_DIVHI, 8'h00);
		apb(1'h0, 10'h0C3, 8'h00, r, e);
		chk("unmapped error", {31'h0, e}, 32'h1);
		chk("unmapped data", r, 32'h0);
		$display("testRegs done");
	endtask
	task automatic testTxTiming();
		logic [8:0] d;
		longint t0, t1;
		logic ok;
		int bitLen;
		logic [31:0] r;
		for (int k = 0; k < 2; k++) begin
			bitLen = 16 * (2 * k + 1);
			wr(`USFF_IDX_DIVLO, 8'(2 * k));
			wr(`USFF_IDX_FMT, 8'h06 | 8'(k << 3));
			wr(`USFF_IDX_CTLB, 8'h08);
			fork
				begin
					u_peer.catchFrame(bitLen, 8, d, t0, ok);
					chk("first frame", {22'h0, ok, d}, 32'h2A5);
					u_peer.catchFrame(bitLen, 8, d, t1, ok);
					chk("second frame", {22'h0, ok, d}, 32'h23C);
				end
				begin
					wr(`USFF_IDX_DATA, 8'hA5);
					r = '0;
					// Second byte goes in once the first has left the buffer
					for (int i = 0; i < 200 && r[5] !== 1'h1; i++) rd(`USFF_IDX_STAT, r);
					wr(`USFF_IDX_DATA, 8'h3C);
				end
			join
			chk("frame spacing", 32'((t1 - t0) / 50), 32'(bitLen * (10 + k)));
			repeat (3 * bitLen) @(posedge clk_sys);
		end
		$display("testTxTiming done");
	endtask
	task automatic testSizes();
		logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
		int nb [5] = '{5, 6, 7, 8, 9};
		logic [8:0] d;
		longint t0;
		logic ok;
		wr(`USFF_IDX_STAT, 8'h02);
		wr(`USFF_IDX_DIVLO, 8'h01);
		for (int i = 0; i < 5; i++) begin
			wr(`USFF_IDX_FMT, {5'h00, codes[i][1:0], 1'h0});
			wr(`USFF_IDX_CTLB, {5'h01, codes[i][2], 2'h1});
			fork
				u_peer.catchFrame(16, nb[i], d, t0, ok);
				wr(`USFF_IDX_DATA, 8'hAB);
			join
			chk("sized frame", {22'h0, ok, d}, {22'h0, 1'h1, 9'(9'h1AB & ((1 << nb[i]) - 1))});
			repeat (48) @(posedge clk_sys);
		end
		wr(`USFF_IDX_STAT, 8'h00);
		$display("testSizes done");
	endtask
	task automatic testRx();
		logic [31:0] r;
		wr(`USFF_IDX_DIVLO, 8'h00);
		for (int s = 0; s < 2; s++) begin
			wr(`USFF_IDX_FMT, 8'h06 | 8'(s << 3));
			wr(`USFF_IDX_CTLB, 8'h14);
			u_peer.sendFrame(16, 9, 9'h15A ^ 9'(s));
			rd(`USFF_IDX_STAT, r);
			chk("rx full", {31'h0, r[7]}, 32'h1);
			rd(`USFF_IDX_CTLB, r);
			chk("rx ninth", {31'h0, r[1]}, 32'h1);
			rd(`USFF_IDX_DATA, r);
			chk("rx data", r, 32'h5A ^ 32'(s));
			rd(`USFF_IDX_STAT, r);
			chk("rx drained", {31'h0, r[7]}, 32'h0);
		end
		$display("testRx done");
	endtask
	task automatic testSync();
		logic [9:0] seen;
		logic [31:0] r;
		wr(`USFF_IDX_FMT, 8'h46);
		wr(`USFF_IDX_CTLB, 8'h18);
		wr(`USFF_IDX_DATA, 8'hC3);
		u_peer.syncXfer(8, {1'h1, 8'h96, 1'h0}, seen);
		chk("sync tx frame", {22'h0, seen}, {22'h0, 1'h1, 8'hC3, 1'h0});
		rd(`USFF_IDX_DATA, r);
		chk("sync rx data", r, 32'h96);
		wr(`USFF_IDX_FMT, 8'h06);
		wr(`USFF_IDX_CTLB, 8'h00);
		$display("testSync done");
	endtask
	task automatic results();
		$display("Checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Whole run is a few thousand cycles; this cuts a hang well after that
	initial begin
		repeat (60000) @(posedge clk_sys);
		n_fail++;
		results();
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'h0;
		testRegs();
		testTxTiming();
		testSizes();
		testRx();
		testSync();
		results();
	end
endmodule
`default_nettype wire
